// *** inc/i2c_target_tx_defines.svh ***
// register offsets, field positions, reset values and status codes of the i2c target block
`ifndef I2C_TARGET_TX_DEFINES_SVH
`define I2C_TARGET_TX_DEFINES_SVH

`define I2CT_OFS_CTRL_SET 8'h00
`define I2CT_OFS_STATUS 8'h04
`define I2CT_OFS_SHIFT_BYTE 8'h08
`define I2CT_OFS_OWN_ADDR 8'h0c
`define I2CT_OFS_IRQ_STAT 8'h10
`define I2CT_OFS_IRQ_CLR 8'h14
`define I2CT_OFS_CTRL_CLR 8'h18
`define I2CT_OFS_IRQ_EN 8'h1c

`define I2CT_BIT_ACK_EN 2
`define I2CT_BIT_SI 3
`define I2CT_BIT_BEGIN 5

`define I2CT_IRQ_SI 0
`define I2CT_IRQ_EXIT 1
`define I2CT_IRQ_END 2
`define I2CT_IRQ_W 3

`define I2CT_RST_OWN_ADDR 8'h00
`define I2CT_RST_SHIFT_BYTE 8'h00
`define I2CT_RST_IRQ_EN 3'h0

`define I2CT_BITS_PER_BYTE 4'h8

`define I2CT_CODE_IDLE 8'hf8
`define I2CT_CODE_OWN_W 8'h60
`define I2CT_CODE_ARB_OWN_W 8'h68
`define I2CT_CODE_GC 8'h70
`define I2CT_CODE_ARB_GC 8'h78
`define I2CT_CODE_RX_ACK 8'h80
`define I2CT_CODE_RX_NACK 8'h88
`define I2CT_CODE_GC_ACK 8'h90
`define I2CT_CODE_GC_NACK 8'h98
`define I2CT_CODE_EXIT 8'ha0
`define I2CT_CODE_OWN_R 8'ha8
`define I2CT_CODE_ARB_OWN_R 8'hb0
`define I2CT_CODE_TX_ACK 8'hb8
`define I2CT_CODE_TX_NACK 8'hc0
`define I2CT_CODE_TX_LAST 8'hc8

`endif

// *** inc/i2c_target_tx_pkg.sv ***
// types shared by the i2c target block and its bus sensing front end
package i2c_target_tx_pkg;

  typedef enum logic [3:0] {
    ST_NADDR = 4'h0,
    ST_ADDR = 4'h1,
    ST_A_ACK = 4'h2,
    ST_WAIT = 4'h3,
    ST_TX = 4'h4,
    ST_TX_ACK = 4'h5,
    ST_RX = 4'h6,
    ST_R_ACK = 4'h7
  } tgt_state_type;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda_lvl;
  } sense_state_type;

  typedef struct packed {
    tgt_state_type st;
    logic [7:0] code;
    logic si;
    logic ack_en;
    logic begin_req;
    logic [7:0] shift_byte;
    logic [7:0] own_addr;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic last;
    logic acked;
    logic is_gc;
    logic arb;
    logic busy;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] rdata;
    logic sda_oe;
    logic scl_oe;
    logic start_go;
    logic irq;
  } tgt_state_full_type;

endpackage

// *** logic/i2c_bus_sense.sv ***
// synchroniser and start, stop and clock edge detector for the i2c pins
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_sense
  import i2c_target_tx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out,
  output logic sda_lvl_out
);

  sense_state_type q;
  sense_state_type nxt_q;

  // bit 1 is scl, bit 0 is sda; sync1 feeds only sync2
  always_comb begin
    nxt_q = q;
    nxt_q.sync1 = {scl_pin_in, sda_pin_in};
    nxt_q.sync2 = q.sync1;
    nxt_q.prev = q.sync2;
    nxt_q.scl_rise = q.sync2[1] & ~q.prev[1];
    nxt_q.scl_fall = ~q.sync2[1] & q.prev[1];
    nxt_q.start = q.sync2[1] & q.prev[1] & q.prev[0] & ~q.sync2[0];
    nxt_q.stop = q.sync2[1] & q.prev[1] & ~q.prev[0] & q.sync2[0];
    nxt_q.sda_lvl = q.sync2[0];
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{sync1: 2'h3, sync2: 2'h3, prev: 2'h3, sda_lvl: 1'b1, default: '0};
    end else if (ce_in) begin
      q <= nxt_q;
    end
  end

  assign scl_rise_out = q.scl_rise;
  assign scl_fall_out = q.scl_fall;
  assign start_out = q.start;
  assign stop_out = q.stop;
  assign sda_lvl_out = q.sda_lvl;

endmodule

`default_nettype wire

// *** logic/i2c_target_tx.sv ***
// i2c target: address recognition, target transmit and receive, exit on stop or repeated start
// Function
// R1 - software sets own address and control before the target can answer.
// R2 - transmit mode entered only on own address with read direction bit one.
// R3 - own address plus read received sets interrupt flag and a valid code.
// R4 - code 0xa8 after own address plus read acknowledged.
// R5 - arbitration lost as initiator then read-addressed: acknowledge, code 0xb0.
// R6 - code 0xb8 after data byte sent and acknowledged by master.
// R7 - in 0xa8/0xb0/0xb8 software loads byte, clears flag; byte sent, ack sampled.
// R8 - byte loaded with ack enable low is the last; its ack still sampled.
// R9 - ack enable cleared: final byte sent, then code 0xc0 or 0xc8.
// R10 - after the last byte ignore master clocks, keep data line released.
// R11 - ack enable low: own address and general call ignored, bus still watched.
// R12 - stop or repeated start while addressed: code 0xa0, back to not addressed.
// R13 - general call byte not acknowledged: not addressed, whatever control says.
// R14 - not addressed with ack enable low: no address is recognised.
// R15 - ack enable high: own address recognised, general call when address bit 0 set.
// R16 - begin request on exit: not addressed first, then start once bus free.
// R17 - while the flag is set in a target state, hold the clock line low.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "i2c_target_tx_defines.svh"

module i2c_target_tx
  import i2c_target_tx_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic arb_lost_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic start_go_out,
  output logic irq_out
);

  tgt_state_full_type q;
  tgt_state_full_type nxt_q;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda_lvl;

  i2c_bus_sense u_sense (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .scl_pin_in(scl_in),
    .sda_pin_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(bus_start),
    .stop_out(bus_stop),
    .sda_lvl_out(sda_lvl)
  );

  function automatic logic is_tx_code(input logic [7:0] c);
    is_tx_code = (c == `I2CT_CODE_OWN_R) || (c == `I2CT_CODE_ARB_OWN_R) ||
                 (c == `I2CT_CODE_TX_ACK);
  endfunction

  function automatic logic is_exit_code(input logic [7:0] c);
    is_exit_code = (c == `I2CT_CODE_TX_NACK) || (c == `I2CT_CODE_TX_LAST) ||
                   (c == `I2CT_CODE_RX_NACK) || (c == `I2CT_CODE_GC_NACK);
  endfunction

  always_comb begin
    logic match_own;
    logic match_gc;
    logic [3:0] nb;
    logic [7:0] shl;
    logic [2:0] ev;
    match_own = 1'b0;
    match_gc = 1'b0;
    nb = 4'h0;
    shl = 8'h00;
    ev = 3'h0;
    nxt_q = q;
    nxt_q.start_go = 1'b0;
    nxt_q.rdata = '0;

    // register reads: data stands the cycle after the strobe
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `I2CT_OFS_CTRL_SET: begin
          nxt_q.rdata[`I2CT_BIT_ACK_EN] = q.ack_en;
          nxt_q.rdata[`I2CT_BIT_SI] = q.si;
          nxt_q.rdata[`I2CT_BIT_BEGIN] = q.begin_req;
        end
        `I2CT_OFS_STATUS: nxt_q.rdata[7:0] = q.si ? q.code : `I2CT_CODE_IDLE;
        `I2CT_OFS_SHIFT_BYTE: nxt_q.rdata[7:0] = q.shift_byte;
        `I2CT_OFS_OWN_ADDR: nxt_q.rdata[7:0] = q.own_addr;
        `I2CT_OFS_IRQ_STAT: nxt_q.rdata[2:0] = q.irq_stat;
        `I2CT_OFS_IRQ_EN: nxt_q.rdata[2:0] = q.irq_en;
        default: nxt_q.rdata = '0;
      endcase
    end

    // register writes; hardware sets below override software clears
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `I2CT_OFS_CTRL_SET: begin
          if (reg_wdata_in[`I2CT_BIT_ACK_EN]) begin
            nxt_q.ack_en = 1'b1;
          end
          if (reg_wdata_in[`I2CT_BIT_BEGIN]) begin
            nxt_q.begin_req = 1'b1;
          end
        end
        `I2CT_OFS_CTRL_CLR: begin
          if (reg_wdata_in[`I2CT_BIT_ACK_EN]) begin
            nxt_q.ack_en = 1'b0;
          end
          if (reg_wdata_in[`I2CT_BIT_SI]) begin
            nxt_q.si = 1'b0;
          end
          if (reg_wdata_in[`I2CT_BIT_BEGIN]) begin
            nxt_q.begin_req = 1'b0;
          end
        end
        `I2CT_OFS_SHIFT_BYTE: nxt_q.shift_byte = reg_wdata_in[7:0];
        `I2CT_OFS_OWN_ADDR: nxt_q.own_addr = reg_wdata_in[7:0];
        `I2CT_OFS_IRQ_CLR: nxt_q.irq_stat = q.irq_stat & ~reg_wdata_in[2:0];
        `I2CT_OFS_IRQ_EN: nxt_q.irq_en = reg_wdata_in[2:0];
        default: ;
      endcase
    end

    if (arb_lost_in) begin
      nxt_q.arb = 1'b1;
    end
    if (bus_start) begin
      nxt_q.busy = 1'b1;
    end
    if (bus_stop) begin
      nxt_q.busy = 1'b0;
    end

    unique case (q.st)
      ST_NADDR: begin
        // bus stays monitored here even with ack enable low [R11]
        nxt_q.sda_oe = 1'b0;
        nxt_q.scl_oe = 1'b0;
        if (bus_start) begin
          nxt_q.st = ST_ADDR;
          nxt_q.bitcnt = 4'h0;
        end
      end
      ST_ADDR: begin
        if (bus_stop) begin
          nxt_q.st = ST_NADDR;
        end else if (bus_start) begin
          nxt_q.bitcnt = 4'h0;
        end else if (scl_rise && q.bitcnt != `I2CT_BITS_PER_BYTE) begin
          nxt_q.sh = {q.sh[6:0], sda_lvl};
          nxt_q.bitcnt = q.bitcnt + 4'h1;
        end else if (scl_fall && q.bitcnt == `I2CT_BITS_PER_BYTE) begin
          // a pending flag from an earlier exit also blocks recognition
          match_own = q.ack_en && !q.si && (q.sh[7:1] == q.own_addr[7:1]); // [R1] [R14]
          match_gc = q.ack_en && !q.si && q.own_addr[0] && (q.sh == 8'h00); // [R15] [R11]
          if (match_own || match_gc) begin
            nxt_q.sda_oe = 1'b1;
            nxt_q.st = ST_A_ACK;
            nxt_q.is_gc = match_gc;
            nxt_q.arb = arb_lost_in; // a loss in this very cycle must not be lost
            if (match_gc) begin
              nxt_q.code = q.arb ? `I2CT_CODE_ARB_GC : `I2CT_CODE_GC;
            end else if (q.sh[0]) begin
              nxt_q.code = q.arb ? `I2CT_CODE_ARB_OWN_R : `I2CT_CODE_OWN_R; // [R2] [R4] [R5]
            end else begin
              nxt_q.code = q.arb ? `I2CT_CODE_ARB_OWN_W : `I2CT_CODE_OWN_W;
            end
          end else begin
            nxt_q.st = ST_NADDR;
          end
        end
      end
      ST_A_ACK: begin
        if (scl_fall) begin
          nxt_q.sda_oe = 1'b0;
          nxt_q.si = 1'b1; // [R3]
          ev[`I2CT_IRQ_SI] = 1'b1;
          nxt_q.scl_oe = 1'b1;
          nxt_q.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // the master is stalled on a low clock until software answers [R17]
        nxt_q.scl_oe = 1'b1;
        if (!q.si) begin
          nxt_q.scl_oe = 1'b0;
          nxt_q.bitcnt = 4'h0;
          if (is_tx_code(q.code)) begin
            nxt_q.sh = q.shift_byte; // [R7]
            nxt_q.last = !q.ack_en; // [R8] [R9]
            nxt_q.sda_oe = ~q.shift_byte[7];
            nxt_q.st = ST_TX;
          end else if (is_exit_code(q.code)) begin
            // control bits cannot keep the target addressed here [R13] [R10]
            nxt_q.st = ST_NADDR;
          end else begin
            nxt_q.st = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          nb = q.bitcnt + 4'h1;
          shl = {q.sh[6:0], 1'b1};
          nxt_q.bitcnt = nb;
          nxt_q.sh = shl;
          if (nb == `I2CT_BITS_PER_BYTE) begin
            nxt_q.sda_oe = 1'b0;
            nxt_q.st = ST_TX_ACK;
          end else begin
            nxt_q.sda_oe = ~shl[7];
          end
        end
      end
      ST_TX_ACK: begin
        if (scl_rise) begin
          nxt_q.acked = ~sda_lvl; // [R7] [R8]
        end
        if (scl_fall) begin
          if (!q.acked) begin
            nxt_q.code = `I2CT_CODE_TX_NACK; // [R9]
            ev[`I2CT_IRQ_END] = 1'b1;
          end else if (q.last) begin
            nxt_q.code = `I2CT_CODE_TX_LAST; // [R9]
            ev[`I2CT_IRQ_END] = 1'b1;
          end else begin
            nxt_q.code = `I2CT_CODE_TX_ACK; // [R6]
          end
          nxt_q.si = 1'b1;
          ev[`I2CT_IRQ_SI] = 1'b1;
          nxt_q.scl_oe = 1'b1;
          nxt_q.st = ST_WAIT;
        end
      end
      ST_RX: begin
        if (scl_rise && q.bitcnt != `I2CT_BITS_PER_BYTE) begin
          nxt_q.sh = {q.sh[6:0], sda_lvl};
          nxt_q.bitcnt = q.bitcnt + 4'h1;
        end else if (scl_fall && q.bitcnt == `I2CT_BITS_PER_BYTE) begin
          nxt_q.shift_byte = q.sh;
          nxt_q.acked = q.ack_en;
          nxt_q.sda_oe = q.ack_en;
          nxt_q.st = ST_R_ACK;
        end
      end
      ST_R_ACK: begin
        if (scl_fall) begin
          nxt_q.sda_oe = 1'b0;
          if (q.is_gc) begin
            nxt_q.code = q.acked ? `I2CT_CODE_GC_ACK : `I2CT_CODE_GC_NACK; // [R13]
          end else begin
            nxt_q.code = q.acked ? `I2CT_CODE_RX_ACK : `I2CT_CODE_RX_NACK;
          end
          if (!q.acked) begin
            ev[`I2CT_IRQ_END] = 1'b1;
          end
          nxt_q.si = 1'b1;
          ev[`I2CT_IRQ_SI] = 1'b1;
          nxt_q.scl_oe = 1'b1;
          nxt_q.st = ST_WAIT;
        end
      end
      default: begin
        nxt_q.st = ST_NADDR;
        nxt_q.sda_oe = 1'b0;
        nxt_q.scl_oe = 1'b0;
      end
    endcase

    // stop or repeated start while addressed ends the session
    if ((bus_start || bus_stop) && q.st != ST_NADDR && q.st != ST_ADDR) begin
      nxt_q.code = `I2CT_CODE_EXIT; // [R12]
      nxt_q.si = 1'b1;
      ev[`I2CT_IRQ_SI] = 1'b1;
      ev[`I2CT_IRQ_EXIT] = 1'b1;
      nxt_q.sda_oe = 1'b0;
      nxt_q.scl_oe = 1'b0;
      nxt_q.bitcnt = 4'h0;
      nxt_q.st = bus_start ? ST_ADDR : ST_NADDR; // [R12]
    end

    // start request waits for not-addressed mode and a free bus
    if (q.begin_req && q.st == ST_NADDR && !q.si && !q.busy && !bus_start) begin
      nxt_q.start_go = 1'b1; // [R16]
      nxt_q.begin_req = 1'b0; // [R16]
    end

    nxt_q.irq_stat = nxt_q.irq_stat | ev;
    nxt_q.irq = |(nxt_q.irq_stat & nxt_q.irq_en);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{
        st: ST_NADDR,
        code: `I2CT_CODE_IDLE,
        shift_byte: `I2CT_RST_SHIFT_BYTE,
        own_addr: `I2CT_RST_OWN_ADDR,
        irq_en: `I2CT_RST_IRQ_EN,
        default: '0
      };
    end else if (ce_in) begin
      q <= nxt_q;
    end
  end

  // open-drain pins only ever pull low, so the driven level is a constant zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (ce_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  assign reg_rdata_out = q.rdata[DATA_W-1:0];
  assign scl_oe_out = q.scl_oe;
  assign sda_oe_out = q.sda_oe;
  assign start_go_out = q.start_go;
  assign irq_out = q.irq;

endmodule

`default_nettype wire

// *** testbench/i2c_master_model.sv ***
// master receiver partner model on open-drain scl and sda with pull-ups
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  output logic scl_low_out,
  output logic sda_low_out,
  input wire logic scl_in,
  input wire logic sda_in
);
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // pin changes land on clock edges, so they are non-blocking to keep the target race free
  task automatic start_cond();
    #50 sda_low_out <= 1'b0;
    #50 scl_low_out <= 1'b0;
    wait (scl_in);
    #100 sda_low_out <= 1'b1;
    #100 scl_low_out <= 1'b1;
  endtask

  // one 200 ns bit; the low phase is long enough for the target to start a stretch
  task automatic bit_xfer(input logic b, output logic r);
    #50 sda_low_out <= ~b;
    #75 scl_low_out <= 1'b0;
    wait (scl_in);
    #75 r = sda_in;
    scl_low_out <= 1'b1;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~ack, r);
  endtask

  task automatic stop_cond();
    #50 sda_low_out <= 1'b1;
    #50 scl_low_out <= 1'b0;
    wait (scl_in);
    #100 sda_low_out <= 1'b0;
    #200;
  endtask
endmodule

`default_nettype wire

// *** testbench/i2c_target_tx_chk.sv ***
// port-level assertions for the i2c target block
`timescale 1ns/1ps
`default_nettype none

`include "i2c_target_tx_defines.svh"

module i2c_target_tx_chk #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic arb_lost_in,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic start_go_out,
  input wire logic irq_out
);
  logic clr_si;
  assign clr_si = reg_wr_in && reg_addr_in == `I2CT_OFS_CTRL_CLR && reg_wdata_in[`I2CT_BIT_SI];

  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data not zero outside a read answer");
  status_code_a: assert property (reg_rd_in && reg_addr_in == `I2CT_OFS_STATUS |=>
    reg_rdata_out[DATA_W-1:8] == '0 && reg_rdata_out[2:0] == 3'h0 && reg_rdata_out[7:5] != 3'h0)
    else $error("status read is not a valid state code");
  irq_mask_a: assert property (reg_wr_in && reg_addr_in == `I2CT_OFS_IRQ_EN &&
    reg_wdata_in[2:0] == 3'h0 |=> ##1 !irq_out)
    else $error("interrupt stays high with all enables off");
  stretch_release_a: assert property (clr_si |-> ##[1:3] !scl_oe_out)
    else $error("clock stretch not released after flag clear");
  stretch_hold_a: assert property ($fell(scl_oe_out) |->
    $past(clr_si) || $past(clr_si, 2) || $past(clr_si, 3))
    else $error("clock stretch ended without a flag clear");
  stretch_low_a: assert property ($rose(scl_oe_out) |-> !$past(scl_in, 2))
    else $error("clock stretch began during a high clock phase");
  data_low_phase_a: assert property ($rose(sda_oe_out) |-> !$past(scl_in))
    else $error("data line pulled low while clock high");
  go_pulse_a: assert property (start_go_out |=> !start_go_out)
    else $error("start request longer than one cycle");
  go_free_a: assert property (start_go_out |-> !scl_oe_out && !sda_oe_out)
    else $error("start request while still driving the bus");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output value not low");
endmodule

bind i2c_target_tx i2c_target_tx_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .arb_lost_in(arb_lost_in), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .start_go_out(start_go_out), .irq_out(irq_out)
);

`default_nettype wire

// *** testbench/tb_i2c_target_transmit_states.sv ***
// bench for the i2c target: register port, master receiver partner, reference queue
`timescale 1ns/1ps
`default_nettype none

`include "i2c_target_tx_defines.svh"

module tb_i2c_target_transmit_states;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] r_addr = 8'h00;
  logic [31:0] r_wdata = 32'h0;
  logic r_wr = 1'b0;
  logic r_rd = 1'b0;
  logic arb = 1'b0;
  logic [31:0] rdata;
  logic scl_oe, sda_oe, scl_low, sda_low, go, irq, ack, last;
  wire logic scl_w = ~(scl_oe | scl_low);
  wire logic sda_w = ~(sda_oe | sda_low);
  int fails = 0;
  int compares = 0;
  int go_cnt = 0;
  int n;
  logic [7:0] got;
  logic [7:0] seed = 8'h19;
  logic [31:0] d;
  logic [7:0] exq[$];
  logic [7:0] ab [6] = '{8'hb5, 8'hb4, 8'h00, 8'h00, 8'hb5, 8'h7f};
  logic [7:0] ex [6] = '{`I2CT_CODE_OWN_R, `I2CT_CODE_OWN_W, `I2CT_CODE_GC, 8'h0, 8'h0, 8'h0};
  logic [5:0] ae = 6'b101111;
  logic [5:0] gce = 6'b110111;

  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (go === 1'b1) go_cnt++;

  i2c_target_tx dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .reg_addr_in(r_addr),
    .reg_wdata_in(r_wdata), .reg_wr_in(r_wr), .reg_rd_in(r_rd), .reg_rdata_out(rdata),
    .arb_lost_in(arb), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(sda_oe), .start_go_out(go), .irq_out(irq)
  );
  i2c_master_model mst_u (
    .scl_low_out(scl_low), .sda_low_out(sda_low), .scl_in(scl_w), .sda_in(sda_w)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    r_addr <= a;
    r_wdata <= v;
    r_wr <= 1'b1;
    @(posedge clk_in);
    r_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    r_addr <= a;
    r_rd <= 1'b1;
    @(posedge clk_in);
    r_rd <= 1'b0;
    #1 v = rdata;
  endtask

  // a missing flag shows up as a wrong code rather than a hang
  task automatic sw_code(input logic [7:0] code);
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_in);
    bus_rd(`I2CT_OFS_STATUS, d);
    chk(d, {24'h0, code});
  endtask

  // the flag is cleared last because that write lets the clock go
  task automatic release_si(input logic ack_en, input logic beg);
    bus_wr(`I2CT_OFS_IRQ_CLR, 32'h7);
    bus_wr(`I2CT_OFS_CTRL_SET, {26'h0, beg, 2'h0, ack_en, 2'h0});
    bus_wr(`I2CT_OFS_CTRL_CLR, {28'h0, 1'b1, ~ack_en, 2'h0});
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk_in);
    #1 chk(irq, e);
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    bus_rd(`I2CT_OFS_STATUS, d);
    chk(d, 32'hf8);
    bus_rd(8'h20, d);
    chk(d, 32'h0);
    bus_wr(`I2CT_OFS_IRQ_EN, 32'h7);
    bus_rd(`I2CT_OFS_IRQ_EN, d);
    chk(d, 32'h7);
    for (int i = 0; i < 6; i++) begin
      bus_wr(`I2CT_OFS_OWN_ADDR, {24'h0, 7'h5a, gce[i]});
      bus_wr(ae[i] ? `I2CT_OFS_CTRL_SET : `I2CT_OFS_CTRL_CLR, 32'h4);
      mst_u.start_cond();
      mst_u.send_byte(ab[i], ack);
      chk(ack, ex[i] != 8'h0);
      if (ack) begin
        sw_code(ex[i]);
        bus_wr(`I2CT_OFS_SHIFT_BYTE, 32'hff);
        release_si(1'b1, 1'b0);
      end
      mst_u.stop_cond();
      if (ack) begin
        sw_code(`I2CT_CODE_EXIT);
        n = go_cnt;
        release_si(1'b1, 1'b1);
        repeat (20) @(posedge clk_in);
        chk(go_cnt - n, 1);
      end
    end
    // general call data refused: the target must drop out whatever control says
    mst_u.start_cond();
    mst_u.send_byte(8'h00, ack);
    sw_code(`I2CT_CODE_GC);
    release_si(1'b0, 1'b0);
    mst_u.send_byte(seed, ack);
    chk(ack, 1'b0);
    sw_code(`I2CT_CODE_GC_NACK);
    bus_rd(`I2CT_OFS_SHIFT_BYTE, d);
    chk(d, {24'h0, seed});
    release_si(1'b1, 1'b0);
    mst_u.send_byte(8'hb5, ack);
    chk(ack, 1'b0);
    mst_u.stop_cond();
    sw_code(`I2CT_CODE_IDLE);
    for (int t = 0; t < 2; t++) begin
      if (t == 0) begin
        @(posedge clk_in);
        arb <= 1'b1;
        @(posedge clk_in);
        arb <= 1'b0;
      end
      mst_u.start_cond();
      mst_u.send_byte(8'hb5, ack);
      sw_code(t ? `I2CT_CODE_OWN_R : `I2CT_CODE_ARB_OWN_R);
      for (int k = 0; k < 3 - t; k++) begin
        seed = lfsr(seed);
        exq.push_back(seed);
        last = (t == 0 && k == 2);
        bus_wr(`I2CT_OFS_SHIFT_BYTE, {24'h0, seed});
        fork
          release_si(!last, 1'b0);
          mst_u.recv_byte(!(t == 1 && k == 1), got);
        join
        chk(got, exq.pop_front());
        sw_code((t == 1 && k == 1) ? `I2CT_CODE_TX_NACK :
          last ? `I2CT_CODE_TX_LAST : `I2CT_CODE_TX_ACK);
      end
      bus_rd(`I2CT_OFS_IRQ_STAT, d);
      chk(d, 32'h5);
      bus_wr(`I2CT_OFS_IRQ_EN, 32'h0);
      chk_irq(1'b0);
      bus_wr(`I2CT_OFS_IRQ_EN, 32'h7);
      chk_irq(1'b1);
      release_si(1'b1, 1'b0);
      if (t == 0) begin
        mst_u.recv_byte(1'b0, got);
        chk(got, 32'hff);
      end
      mst_u.stop_cond();
      sw_code(`I2CT_CODE_IDLE);
    end
    complete_run();
  end

  // roughly ten times the expected length of the run
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
